/* File: ddss_consts.svh */
`ifndef DDSS_CONSTS_SVH
`define DDSS_CONSTS_SVH

// register byte offsets
`define DDSS_ADDR_W       6
`define DDSS_OFF_CTRL     6'h00
`define DDSS_OFF_FBSEL    6'h04
`define DDSS_OFF_EXCL     6'h08
`define DDSS_OFF_STATUS   6'h0c
`define DDSS_OFF_DDLY0    6'h10
`define DDSS_OFF_DDLY5    6'h24

// widths and reset values
`define DDSS_NOUT         6
`define DDSS_DLY_W        10
`define DDSS_CNT_W        12
`define DDSS_CTRL_W       7
`define DDSS_CTRL_RST     7'h00
`define DDSS_FBSEL_RST    2'h0
`define DDSS_EXCL_RST     6'h00
`define DDSS_DLY_RST      10'h000

// feedback selector codes
`define DDSS_FB_OUT0      2'h0
`define DDSS_FB_OUT2      2'h1
`define DDSS_FB_OUT4      2'h2
`define DDSS_FB_EXT       2'h3

// sequence timing in distribution cycles, rise delay in half cycles
`define DDSS_ARM_LEN      3
`define DDSS_PULSE_LEN    3
`define DDSS_FORCE_LOW    5
`define DDSS_RISE_HALF    11
`define DDSS_RISE_CYC     ((`DDSS_RISE_HALF + 1) / 2)

`endif

/* File: ddss_host.sv */
`timescale 1ns/1ns
module ddss_host (
    // clock and bus answer
    input  wire logic        clock,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    // bus request
    output logic      [5:0]  address,
    output logic             read,
    output logic             write,
    output logic      [3:0]  byteenable,
    output logic      [31:0] writedata
);
    initial begin
        address    = 6'h00;
        read       = 1'b0;
        write      = 1'b0;
        byteenable = 4'h0;
        writedata  = 32'h0000_0000;
    end

    // call just after a rising edge; the request stands until the rising
    // edge at which waitrequest is seen low, data is taken at that edge
    task automatic xfer(input logic wr_en, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        address    <= a;
        writedata  <= d;
        byteenable <= 4'hf;
        write      <= wr_en;
        read       <= ~wr_en;
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        // one idle edge so the next call never re-raises in this step
        @(posedge clock);
    endtask : xfer
endmodule : ddss_host

/* File: ddss_pkg.sv */
package ddss_pkg;

    typedef enum logic [5:0] {
        DDSS_IDLE  = 6'h01,
        DDSS_QUAL1 = 6'h02,
        DDSS_QUAL2 = 6'h04,
        DDSS_ARM   = 6'h08,
        DDSS_PULSE = 6'h10,
        DDSS_HOLD  = 6'h20
    } ddss_state_e;

    typedef struct packed {
        logic out2_power_down;
        logic zero_delay_enable;
        logic loop1_lockloss_holdover_block;
        logic feedback_select_enable;
        logic sync_output_qualify;
        logic sync_polarity_invert;
        logic auto_sync_enable;
    } ddss_ctrl_s;

endpackage : ddss_pkg

/* File: ddss_sync2.sv */
`timescale 1ns/1ns
module ddss_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : ddss_sync2

/* File: ddss_top.sv */
// Operation
// - with auto sync on, a delay register write starts a sync by itself.
// - with auto sync off, a pin or polarity toggle requests a sync.
// - a request becomes an internal one-shot; no host timing needed.
// - after latching, wait first then second qualifying falling edge.
// - five cycles after the one-shot begins, synced outputs go low.
// - outputs rise 6 cycles (5.5 rounded up) plus their delay after one-shot ends.
// - sync-excluded outputs keep toggling untouched during a sync.
// - selector code one routes output two to the qualify path.
// - zero-delay mode with feedback select on feeds selected output to loop one divider.
// - with lock-loss block set, loop one unlock raises no holdover.
// - one-shot starts three cycles after qualification, lasts three.
`timescale 1ns/1ns
`include "ddss_consts.svh"
module ddss_top (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    // avalon-mm slave
    input  wire logic [`DDSS_ADDR_W-1:0] address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [3:0]              byteenable,
    input  wire logic [31:0]             writedata,
    output logic      [31:0]             readdata,
    output logic                         waitrequest,
    // device pins
    input  wire logic                    sync_pin,
    input  wire logic                    lock_detect,
    input  wire logic                    external_feedback_input,
    // divider bank
    input  wire logic [`DDSS_NOUT-1:0]   div_clk,
    output logic      [`DDSS_NOUT-1:0]   out_clk,
    output logic      [`DDSS_NOUT-1:0]   out_restart,
    // loop one, holdover and one-shot
    output logic                         loop1_feedback_divider,
    output logic                         holdover_request,
    output logic                         sync_pulse
);
    ddss_pkg::ddss_ctrl_s              ctrl_r;
    ddss_pkg::ddss_state_e             state_r;
    logic [1:0]                        fbsel_r;
    logic [`DDSS_NOUT-1:0]             excl_r;
    logic [`DDSS_DLY_W-1:0]            ddly_r [`DDSS_NOUT];
    logic [`DDSS_NOUT-1:0]             gate_r;
    logic [`DDSS_CNT_W-1:0]            cnt_r;
    logic                              pend_r;
    logic                              req_prev_r;
    logic                              qclk_prev_r;
    logic [2:0]                        pins_s;
    logic                              sync_s;
    logic                              lock_s;
    logic                              extfb_s;
    logic                              acc;
    logic                              wr_acc;
    logic                              req_lvl;
    logic                              toggle;
    logic                              ddly_wr;
    logic                              qclk;
    logic                              qfall;

    ddss_sync2 #(.W(3)) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({external_feedback_input, lock_detect, sync_pin}),
        .sync_out (pins_s)
    );
    assign sync_s  = pins_s[0];
    assign lock_s  = pins_s[1];
    assign extfb_s = pins_s[2];

    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge_be

    function automatic logic fb_mux(input logic [1:0]            sel,
                                    input logic [`DDSS_NOUT-1:0] clk,
                                    input logic                  ext);
        logic r;
        case (sel)
            `DDSS_FB_OUT0: r = clk[0];
            `DDSS_FB_OUT2: r = clk[2];
            `DDSS_FB_OUT4: r = clk[4];
            default:       r = ext;
        endcase
        return r;
    endfunction : fb_mux

    function automatic logic is_ddly(input logic [`DDSS_ADDR_W-1:0] a);
        return a >= `DDSS_OFF_DDLY0 && a <= `DDSS_OFF_DDLY5 &&
               a[1:0] == 2'h0;
    endfunction : is_ddly

    // one cycle of wait on every access keeps decode off the bus path
    assign acc    = (read | write) & waitrequest;
    assign wr_acc = write & ~waitrequest;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~acc;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0000_0000;
        end else if (read & acc) begin
            readdata <= 32'h0000_0000;
            case (address)
                `DDSS_OFF_CTRL:   readdata[`DDSS_CTRL_W-1:0] <= ctrl_r;
                `DDSS_OFF_FBSEL:  readdata[1:0] <= fbsel_r;
                `DDSS_OFF_EXCL:   readdata[`DDSS_NOUT-1:0] <= excl_r;
                `DDSS_OFF_STATUS: readdata[19:0] <=
                    {lock_s, pend_r, gate_r, state_r, out_clk};
                default: begin
                    if (is_ddly(address)) begin
                        readdata[`DDSS_DLY_W-1:0] <=
                            ddly_r[3'(address[4:2] - 3'h4)];
                    end
                end
            endcase
        end
    end

    // control registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= `DDSS_CTRL_RST;
            fbsel_r <= `DDSS_FBSEL_RST;
            excl_r  <= `DDSS_EXCL_RST;
        end else if (wr_acc) begin
            case (address)
                `DDSS_OFF_CTRL:  ctrl_r <= `DDSS_CTRL_W'(merge_be(
                    32'(ctrl_r), writedata, byteenable));
                `DDSS_OFF_FBSEL: fbsel_r <= 2'(merge_be(
                    32'(fbsel_r), writedata, byteenable));
                `DDSS_OFF_EXCL:  excl_r <= `DDSS_NOUT'(merge_be(
                    32'(excl_r), writedata, byteenable));
                default: ;
            endcase
        end
    end

    // per-output digital delay counts
    assign ddly_wr = wr_acc & is_ddly(address);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `DDSS_NOUT; i++) begin
                ddly_r[i] <= `DDSS_DLY_RST;
            end
        end else if (ddly_wr) begin
            ddly_r[3'(address[4:2] - 3'h4)] <= `DDSS_DLY_W'(merge_be(
                32'(ddly_r[3'(address[4:2] - 3'h4)]), writedata,
                byteenable));
        end
    end

    // request detection; polarity write and pin both land here
    assign req_lvl = sync_s ^ ctrl_r.sync_polarity_invert;
    assign toggle  = req_lvl ^ req_prev_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_prev_r <= 1'b0;
        end else begin
            req_prev_r <= req_lvl;
        end
    end

    // set wins over the clear taken when the sequence starts
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else if (ddly_wr & ctrl_r.auto_sync_enable) begin
            pend_r <= 1'b1;
        end else if (toggle & ~ctrl_r.auto_sync_enable) begin
            pend_r <= 1'b1;
        end else if (state_r == ddss_pkg::DDSS_IDLE) begin
            pend_r <= 1'b0;
        end
    end

    // qualifying clock, output two on code one
    assign qclk  = ctrl_r.feedback_select_enable &
                   fb_mux(fbsel_r, div_clk, extfb_s);
    assign qfall = qclk_prev_r & ~qclk;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            qclk_prev_r <= 1'b0;
        end else begin
            qclk_prev_r <= qclk;
        end
    end

    // sequencer; counter runs from the one-shot start to release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ddss_pkg::DDSS_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ddss_pkg::DDSS_IDLE: begin
                    cnt_r <= '0;
                    if (pend_r) begin
                        state_r <= ctrl_r.sync_output_qualify ?
                            ddss_pkg::DDSS_QUAL1 : ddss_pkg::DDSS_ARM;
                    end
                end
                ddss_pkg::DDSS_QUAL1: begin
                    if (qfall) begin
                        state_r <= ddss_pkg::DDSS_QUAL2;
                    end
                end
                ddss_pkg::DDSS_QUAL2: begin
                    if (qfall) begin
                        state_r <= ddss_pkg::DDSS_ARM;
                    end
                end
                ddss_pkg::DDSS_ARM: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == `DDSS_CNT_W'(`DDSS_ARM_LEN - 1)) begin
                        state_r <= ddss_pkg::DDSS_PULSE;
                        cnt_r   <= '0;
                    end
                end
                ddss_pkg::DDSS_PULSE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == `DDSS_CNT_W'(`DDSS_PULSE_LEN - 1)) begin
                        state_r <= ddss_pkg::DDSS_HOLD;
                    end
                end
                ddss_pkg::DDSS_HOLD: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r > `DDSS_CNT_W'(`DDSS_FORCE_LOW) &&
                        gate_r == '0) begin
                        state_r <= ddss_pkg::DDSS_IDLE;
                    end
                end
                default: begin
                    state_r <= ddss_pkg::DDSS_IDLE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_pulse <= 1'b0;
        end else if (state_r == ddss_pkg::DDSS_ARM &&
                     cnt_r == `DDSS_CNT_W'(`DDSS_ARM_LEN - 1)) begin
            sync_pulse <= 1'b1;
        end else if (state_r == ddss_pkg::DDSS_PULSE &&
                     cnt_r == `DDSS_CNT_W'(`DDSS_PULSE_LEN - 1)) begin
            sync_pulse <= 1'b0;
        end
    end

    // output gating; 5.5 cycles round up to whole cycles
    function automatic logic [`DDSS_CNT_W-1:0] rel_cnt(
        input logic [`DDSS_DLY_W-1:0] d);
        return `DDSS_CNT_W'(`DDSS_PULSE_LEN + `DDSS_RISE_CYC - 1) +
               `DDSS_CNT_W'(d);
    endfunction : rel_cnt

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gate_r      <= '0;
            out_restart <= '0;
        end else begin
            out_restart <= '0;
            for (int i = 0; i < `DDSS_NOUT; i++) begin
                if (excl_r[i]) begin
                    gate_r[i] <= 1'b0;
                end else if ((state_r == ddss_pkg::DDSS_PULSE ||
                              state_r == ddss_pkg::DDSS_HOLD) &&
                             cnt_r == `DDSS_CNT_W'(`DDSS_FORCE_LOW - 1))
                begin
                    gate_r[i] <= 1'b1;
                end else if (gate_r[i] && cnt_r == rel_cnt(ddly_r[i]))
                begin
                    gate_r[i]      <= 1'b0;
                    out_restart[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_clk <= '0;
        end else begin
            out_clk <= div_clk & ~gate_r;
        end
    end

    // zero-delay feedback into loop one divider
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loop1_feedback_divider <= 1'b0;
        end else begin
            loop1_feedback_divider <= ctrl_r.zero_delay_enable &
                ctrl_r.feedback_select_enable &
                fb_mux(fbsel_r, div_clk, extfb_s);
        end
    end

    // delay steps disturb lock; the block bit hides that from holdover
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            holdover_request <= 1'b0;
        end else begin
            holdover_request <= ~lock_s &
                ~ctrl_r.loop1_lockloss_holdover_block;
        end
    end

    property p_auto_sync;
        @(posedge clock) disable iff (!rst_n)
        (ddly_wr && ctrl_r.auto_sync_enable) |=> pend_r;
    endproperty
    a_auto_sync: assert property (p_auto_sync)
        else $error("delay write with auto sync did not request");

    property p_manual_sync;
        @(posedge clock) disable iff (!rst_n)
        (toggle && !ctrl_r.auto_sync_enable) |=> pend_r;
    endproperty
    a_manual_sync: assert property (p_manual_sync)
        else $error("toggle did not request a sync");

    property p_pulse_width;
        @(posedge clock) disable iff (!rst_n)
        $rose(sync_pulse) |-> sync_pulse [*3] ##1 !sync_pulse;
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("one-shot width wrong");

    property p_two_edges;
        @(posedge clock) disable iff (!rst_n)
        (state_r == ddss_pkg::DDSS_QUAL1 && qfall) |=>
            state_r == ddss_pkg::DDSS_QUAL2;
    endproperty
    a_two_edges: assert property (p_two_edges)
        else $error("first qualifying edge not taken");

    property p_force_low;
        @(posedge clock) disable iff (!rst_n)
        ($rose(sync_pulse) && $stable(excl_r)) |->
            ##5 (gate_r == ~excl_r);
    endproperty
    a_force_low: assert property (p_force_low)
        else $error("outputs not forced low five cycles after one-shot");

    property p_release;
        @(posedge clock) disable iff (!rst_n)
        $fell(gate_r[2]) && !excl_r[2] |->
            $past(cnt_r) == rel_cnt(ddly_r[2]);
    endproperty
    a_release: assert property (p_release)
        else $error("output two released at wrong count");

    property p_exclude;
        @(posedge clock) disable iff (!rst_n)
        excl_r[0] |=> !gate_r[0] && out_clk[0] == $past(div_clk[0]);
    endproperty
    a_exclude: assert property (p_exclude)
        else $error("excluded output disturbed");

    property p_fb_out2;
        @(posedge clock) disable iff (!rst_n)
        (ctrl_r.zero_delay_enable && ctrl_r.feedback_select_enable &&
         fbsel_r == `DDSS_FB_OUT2) |=>
            loop1_feedback_divider == $past(div_clk[2]);
    endproperty
    a_fb_out2: assert property (p_fb_out2)
        else $error("feedback selector did not route output two");

    property p_holdover_block;
        @(posedge clock) disable iff (!rst_n)
        ctrl_r.loop1_lockloss_holdover_block |=> !holdover_request;
    endproperty
    a_holdover_block: assert property (p_holdover_block)
        else $error("holdover raised while blocked");

    property p_arm_delay;
        @(posedge clock) disable iff (!rst_n)
        $rose(state_r == ddss_pkg::DDSS_ARM) |-> ##3 $rose(sync_pulse);
    endproperty
    a_arm_delay: assert property (p_arm_delay)
        else $error("one-shot not three cycles after qualification");

    property p_detect;
        @(posedge clock) disable iff (!rst_n)
        (req_lvl != $past(req_lvl) && !ctrl_r.auto_sync_enable &&
         !$past(ctrl_r.auto_sync_enable)) |=> pend_r;
    endproperty
    a_detect: assert property (p_detect)
        else $error("xor change missed");

endmodule : ddss_top

/* File: dynamic_delay_sync_sequencer_test.sv */
`timescale 1ns/1ns
`include "ddss_consts.svh"
module dynamic_delay_sync_sequencer_test;
    logic        clock, rst_n, sync_pin, lock_detect, ext_fb, mon_on;
    logic [5:0]  address, div_clk, out_clk, out_restart;
    logic        read, write, waitrequest, sync_pulse;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata, q;
    logic        loop1_feedback_divider, holdover_request;
    int          num_errors, total_checks;

    ddss_top i_ddss_top (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .sync_pin(sync_pin),
        .lock_detect(lock_detect), .external_feedback_input(ext_fb),
        .div_clk(div_clk), .out_clk(out_clk), .out_restart(out_restart),
        .loop1_feedback_divider(loop1_feedback_divider),
        .holdover_request(holdover_request), .sync_pulse(sync_pulse));

    ddss_host i_ddss_host (.clock(clock), .waitrequest(waitrequest),
        .readdata(readdata), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // every divider toggles each cycle, so a registered copy is ~div
    always @(posedge clock) div_clk <= ~div_clk;

    always @(negedge clock) begin
        if (mon_on) chk("out_clk0", 32'(!div_clk[0]), 32'(out_clk[0]));
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        i_ddss_host.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [5:0] a);
        i_ddss_host.xfer(1'b0, a, 32'h0000_0000, q);
    endtask : rd

    // k counts cycles from the first one-shot cycle, output 2 synced
    task automatic seq(input int d);
        int k;
        int n;
        n = 0;
        @(negedge clock);
        while (sync_pulse !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk("pulse_start", 32'h1, 32'(sync_pulse));
        for (k = 0; k <= d + 11; k++) begin
            chk("sync_pulse", 32'(k < 3), 32'(sync_pulse));
            if (k >= 6 && k <= 9 + d)
                chk("out_clk2_low", 32'h0, 32'(out_clk[2]));
            if (k < 5 || k == d + 11)
                chk("out_clk2", 32'(!div_clk[2]), 32'(out_clk[2]));
            chk("restart2", 32'(k == 9 + d), 32'(out_restart[2]));
            chk("restart0", 32'h0, 32'(out_restart[0]));
            @(negedge clock);
        end
        @(posedge clock);
    endtask : seq

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clock);
            chk("no_pulse", 32'h0, 32'(sync_pulse));
        end
        @(posedge clock);
    endtask : quiet

    task automatic test_regs;
        rd(`DDSS_OFF_CTRL);
        chk("ctrl_rst", 32'h0, q);
        rd(6'h18);
        chk("ddly2_rst", 32'h0, q);
        rd(`DDSS_OFF_STATUS);
        chk("state_idle", 32'h1, (q >> 6) & 32'h3f);
        wr(`DDSS_OFF_FBSEL, 32'hffff_ffff);
        rd(`DDSS_OFF_FBSEL);
        chk("fbsel_w", 32'h3, q);
        wr(6'h3c, 32'hffff_ffff);
        rd(6'h3c);
        chk("unmapped", 32'h0, q);
        wr(`DDSS_OFF_EXCL, 32'hffff_ffff);
        rd(`DDSS_OFF_EXCL);
        chk("excl_w", 32'h3f, q);
        wr(`DDSS_OFF_FBSEL, 32'h1);
        wr(`DDSS_OFF_EXCL, 32'h1);
    endtask : test_regs

    task automatic test_auto;
        wr(`DDSS_OFF_CTRL, 32'h1);
        mon_on = 1'b1;
        wr(6'h18, 32'h4);
        seq(4);
        wr(6'h18, 32'hb);
        seq(11);
    endtask : test_auto

    task automatic test_manual;
        wr(`DDSS_OFF_CTRL, 32'h0);
        wr(6'h18, 32'h7);
        quiet(40);
        sync_pin <= 1'b1;
        seq(7);
        wr(`DDSS_OFF_CTRL, 32'h2);
        seq(7);
        // selector off: the request must wait for qualifying edges
        wr(`DDSS_OFF_CTRL, 32'h6);
        sync_pin <= 1'b0;
        quiet(60);
        wr(`DDSS_OFF_CTRL, 32'he);
        seq(7);
    endtask : test_manual

    task automatic test_zero_delay;
        wr(`DDSS_OFF_FBSEL, 32'h2);
        wr(`DDSS_OFF_CTRL, 32'h28);
        repeat (3) @(posedge clock);
        repeat (2) begin
            @(negedge clock);
            chk("fb_div", 32'(!div_clk[4]),
                32'(loop1_feedback_divider));
        end
        @(posedge clock);
        wr(`DDSS_OFF_FBSEL, 32'h1);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("fb_div2", 32'(!div_clk[2]),
            32'(loop1_feedback_divider));
        @(posedge clock);
        wr(`DDSS_OFF_CTRL, 32'h20);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("fb_div_off", 32'h0, 32'(loop1_feedback_divider));
        @(posedge clock);
    endtask : test_zero_delay

    task automatic test_holdover;
        lock_detect <= 1'b0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        chk("holdover", 32'h1, 32'(holdover_request));
        @(posedge clock);
        wr(`DDSS_OFF_CTRL, 32'h10);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk("holdover_blk", 32'h0, 32'(holdover_request));
        @(posedge clock);
        lock_detect <= 1'b1;
    endtask : test_holdover

    task automatic final_report;
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial begin
        #100000;
        num_errors++;
        final_report();
    end

    initial begin
        rst_n        = 1'b0;
        sync_pin     = 1'b0;
        lock_detect  = 1'b1;
        ext_fb       = 1'b0;
        div_clk      = 6'h00;
        mon_on       = 1'b0;
        num_errors   = 0;
        total_checks = 0;
        repeat (4) @(posedge clock);
        chk("wait_rst", 32'h1, 32'(waitrequest));
        rst_n <= 1'b1;
        @(posedge clock);
        test_regs();
        test_auto();
        test_manual();
        test_zero_delay();
        test_holdover();
        final_report();
    end
endmodule : dynamic_delay_sync_sequencer_test
